//--- hdl/charge_status_fault_indicator.sv
// Charger status, temperature hold, bad battery and overvoltage logic.
// Operation
// R01 - Hot or cold thermistor freezes safety timer, stops charge, shows pulses.
// R02 - Valid temperature resumes timer; recharge only when battery below threshold.
// R03 - Grounded thermistor sense disables temperature qualification completely.
// R04 - Active charge without fault holds status pin pulled low continuously.
// R05 - Constant voltage with current under one tenth releases status pin.
// R06 - No input with battery above load, suspend or shutdown: pin released.
// R07 - Bad battery or temperature fault stops charge and selects pulse train.
// R08 - Temperature pulses 1.4 us wide at 35 kHz, starting immediately.
// R09 - Temperature train blinks at 1.5 Hz, each phase inverts polarity.
// R10 - Bad battery pulses 2.8 us at 35 kHz, blinking near 6.1 Hz.
// R11 - Temperature pattern duty is 4.9 or 95.1 percent per phase.
// R12 - Observer classifies fault by measuring status pulse width.
// R13 - Overvoltage sense drives the overvoltage gate output high.
// R14 - Gate output high keeps the input to load power path disabled.
// R15 - High upper and low lower limit select enters suspend mode.
// R16 - Shutdown resets the safety timer and end of charge state.
// R17 - Trickle below low voltage over half an hour declares bad battery.
// R18 - Pulse timing comes from one shared divider; each blink rate has its own counter.
// R19 - Fault patterns take priority over charging and done indications.
`timescale 1ns/100ps
module charge_status_fault_indicator
    import charge_status_pkg::*;
#(
    parameter longint SAFETY_CYCLES = SAFETY_CYC,
    parameter longint BAD_CYCLES = BAD_TIMEOUT_CYC,
    parameter int TEMP_BLINK_CYCLES = TEMP_HALF_CYC,
    parameter int BAD_BLINK_CYCLES = BAD_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic thermistor_cold_in,
    input wire logic thermistor_hot_in,
    input wire logic thermistor_sense_grounded_in,
    input wire logic overvoltage_sense_in,
    input wire logic input_limit_sel_lo_in,
    input wire logic input_limit_sel_hi_in,
    input wire logic shutdown_in,
    input wire logic input_present_in,
    input wire logic battery_above_load_in,
    input wire logic battery_low_in,
    input wire logic below_recharge_in,
    input wire logic cv_mode_in,
    input wire logic current_below_tenth_in,
    input wire logic charge_status_pin_in,
    output logic charge_status_pin_out,
    output logic charge_status_pin_oe_n_out,
    output logic overvoltage_gate_drive_out,
    output logic path_enable_out,
    output logic charge_enable_out,
    output logic trickle_out,
    output logic timer_expired_out
);

    // ********************************************************************
    // Input synchronisers
    // ********************************************************************
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] raw, s1_ff, s2_ff;
    logic cold, hot, ntc_gnd, ov, sel_lo, sel_hi, sd, in_ok, bat_hi;
    logic bat_low, below_rch, cv, low_i;

    assign raw = {thermistor_cold_in, thermistor_hot_in,
                  thermistor_sense_grounded_in, overvoltage_sense_in,
                  input_limit_sel_lo_in, input_limit_sel_hi_in, shutdown_in,
                  input_present_in, battery_above_load_in, battery_low_in,
                  below_recharge_in, cv_mode_in, current_below_tenth_in};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else if (en_in) begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end

    assign {cold, hot, ntc_gnd, ov, sel_lo, sel_hi, sd, in_ok, bat_hi,
            bat_low, below_rch, cv, low_i} = s2_ff;

    // ********************************************************************
    // Charger state and timers
    // ********************************************************************
    chg_state_e state_ff, nxt_state;
    logic [TIMER_W-1:0] safety_ff, nxt_safety;
    logic [TIMER_W-1:0] bad_cnt_ff, nxt_bad_cnt;
    logic eoc_ff, nxt_eoc;
    logic temp_fault, suspend, restart, temp_low, bad_low;
    logic drive_low, nxt_drive_low, drive_ff;

    // Grounded sense masks both comparators, so hold can never start.
    assign temp_fault = (cold || hot) && !ntc_gnd; // R03
    assign suspend = {sel_hi, sel_lo} == SEL_SUSPEND; // R15

    always_comb begin
        nxt_state = state_ff;
        nxt_safety = safety_ff;
        nxt_bad_cnt = bad_cnt_ff;
        nxt_eoc = eoc_ff;
        case (state_ff)
            ST_IDLE: begin
                if (below_rch && in_ok && !ov && !suspend) begin
                    nxt_state = ST_CHARGE;
                    nxt_safety = '0;
                    nxt_bad_cnt = '0;
                    nxt_eoc = 1'b0;
                end
            end
            ST_CHARGE: begin
                if (temp_fault) begin
                    nxt_state = ST_HOLD; // R01
                end else begin
                    if (cv) begin
                        nxt_safety = safety_ff + TIMER_W'(1);
                    end
                    if (cv && low_i) begin
                        nxt_eoc = 1'b1; // R05
                    end
                    if (bat_low) begin
                        nxt_bad_cnt = bad_cnt_ff + TIMER_W'(1);
                    end else begin
                        nxt_bad_cnt = '0;
                    end
                    if (bat_low && bad_cnt_ff >= TIMER_W'(BAD_CYCLES)) begin
                        nxt_state = ST_BAD; // R17
                    end else if (safety_ff >= TIMER_W'(SAFETY_CYCLES)) begin
                        nxt_state = ST_DONE;
                    end
                end
            end
            ST_HOLD: begin
                // Counts stay frozen while held.
                if (!temp_fault) begin // R02
                    nxt_state = below_rch ? ST_CHARGE : ST_IDLE;
                end
            end
            ST_BAD: begin
                nxt_state = ST_BAD;
            end
            ST_DONE: begin
                if (below_rch) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (sd) begin // R16
            nxt_state = ST_IDLE;
            nxt_safety = '0;
            nxt_eoc = 1'b0;
            nxt_bad_cnt = '0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            safety_ff <= '0;
            bad_cnt_ff <= '0;
            eoc_ff <= 1'b0;
            drive_ff <= 1'b0;
        end else if (en_in) begin
            state_ff <= nxt_state;
            safety_ff <= nxt_safety;
            bad_cnt_ff <= nxt_bad_cnt;
            eoc_ff <= nxt_eoc;
            drive_ff <= nxt_drive_low;
        end
    end

    // ********************************************************************
    // Pattern generator and status encoder
    // ********************************************************************
    // Restarting the patterns on fault entry makes the first pulse prompt.
    assign restart = (state_ff == ST_CHARGE) && (nxt_state != ST_CHARGE);

    fault_pattern_gen #(
        .TEMP_BLINK_CYC(TEMP_BLINK_CYCLES),
        .BAD_BLINK_CYC(BAD_BLINK_CYCLES)
    ) u_pattern (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .en_in(en_in),
        .restart_in(restart),
        .temp_low_out(temp_low),
        .bad_low_out(bad_low)
    );

    always_comb begin // R19
        if (sd || suspend || (!in_ok && bat_hi)) begin
            nxt_drive_low = 1'b0; // R06
        end else if (state_ff == ST_BAD) begin
            nxt_drive_low = bad_low; // R07 R10
        end else if (state_ff == ST_HOLD) begin
            nxt_drive_low = temp_low; // R07 R08 R09
        end else if (state_ff == ST_CHARGE) begin
            nxt_drive_low = !eoc_ff; // R04 R05
        end else begin
            nxt_drive_low = 1'b0;
        end
    end

    // The pin is only ever pulled low; released means high impedance.
    assign charge_status_pin_out = 1'b0;
    assign charge_status_pin_oe_n_out = !drive_ff;
    assign overvoltage_gate_drive_out = ov; // R13
    assign path_enable_out = !ov && !suspend && !sd; // R14
    assign charge_enable_out = (state_ff == ST_CHARGE) && !eoc_ff; // R01 R07
    assign trickle_out = (state_ff == ST_CHARGE) && bat_low;
    assign timer_expired_out = (state_ff == ST_DONE);

    // ********************************************************************
    // Checks
    // ********************************************************************
    sequence fault_seen;
        state_ff == ST_CHARGE && temp_fault && !sd;
    endsequence

    ovp_follow_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
        en_in && $rose(overvoltage_sense_in) ##1 en_in
        |=> overvoltage_gate_drive_out)
        else $error("gate drive did not follow overvoltage");
    path_block_a: assert property (@(posedge clk_in) disable iff (rst_in) // R14
        overvoltage_gate_drive_out |-> !path_enable_out)
        else $error("power path open under overvoltage");
    hold_entry_a: assert property (@(posedge clk_in) disable iff (rst_in) // R01
        (en_in and fault_seen) |=> state_ff == ST_HOLD && !charge_enable_out)
        else $error("temperature fault did not enter hold");
    timer_freeze_a: assert property (@(posedge clk_in) disable iff (rst_in) // R01
        state_ff == ST_HOLD && !sd |=> $stable(safety_ff))
        else $error("safety timer moved in hold");
    ntc_gnd_a: assert property (@(posedge clk_in) disable iff (rst_in) // R03
        en_in && ntc_gnd && state_ff == ST_CHARGE |=> state_ff != ST_HOLD)
        else $error("hold entered with grounded sense");
    resume_a: assert property (@(posedge clk_in) disable iff (rst_in) // R02
        en_in && state_ff == ST_HOLD && !temp_fault && !sd && below_rch
        |=> state_ff == ST_CHARGE)
        else $error("charge did not resume after hold");
    charge_low_a: assert property (@(posedge clk_in) disable iff (rst_in) // R04
        en_in && state_ff == ST_CHARGE && !eoc_ff && !sd && !suspend
        && in_ok |=> !charge_status_pin_oe_n_out)
        else $error("pin not pulled low while charging");
    release_a: assert property (@(posedge clk_in) disable iff (rst_in) // R06
        en_in && (sd || suspend) |=> charge_status_pin_oe_n_out)
        else $error("pin not released in suspend or shutdown");
    shutdown_a: assert property (@(posedge clk_in) disable iff (rst_in) // R16
        en_in && sd |=> safety_ff == '0 && !eoc_ff)
        else $error("shutdown did not clear timer state");

endmodule

//--- hdl/charge_status_pkg.sv
// Package with timing counts and field constants for the charge status block.
package charge_status_pkg;

    // ********************************************************************
    // Clock and pattern timing
    // ********************************************************************
    localparam int CLK_MHZ = 200;
    localparam int PERIOD_NS = 5;
    // Pulse repetition: 35 kHz gives a period of about 28.571 us.
    localparam int PULSE_FREQ_HZ = 35000;
    localparam int PULSE_PERIOD_CYC = CLK_MHZ * 1000000 / PULSE_FREQ_HZ;
    // Temperature fault pulse width, 1.4 us, given in ns.
    localparam int TEMP_PULSE_NS = 1400;
    localparam int TEMP_PULSE_CYC = TEMP_PULSE_NS / PERIOD_NS;
    // Bad battery pulse is twice as wide.
    localparam int BAD_PULSE_CYC = 2 * TEMP_PULSE_CYC;
    // Blink rates are given in tenths of a hertz, 50 percent duty.
    localparam int TEMP_BLINK_DHZ = 15;
    localparam int BAD_BLINK_DHZ = 61;
    localparam int TEMP_HALF_CYC =
        CLK_MHZ * 1000000 * 10 / (2 * TEMP_BLINK_DHZ);
    localparam int BAD_HALF_CYC =
        CLK_MHZ * 1000000 * 10 / (2 * BAD_BLINK_DHZ);
    // Bad battery time-out, half an hour, given in seconds.
    localparam int BAD_TIMEOUT_S = 1800;
    localparam longint BAD_TIMEOUT_CYC =
        longint'(BAD_TIMEOUT_S) * CLK_MHZ * 1000000;
    // Safety timer, two hours, given in seconds.
    localparam int SAFETY_S = 7200;
    localparam longint SAFETY_CYC = longint'(SAFETY_S) * CLK_MHZ * 1000000;

    localparam int TIMER_W = 44;
    localparam int DIV_W = 16;
    localparam int BLINK_W = 27;
    localparam logic [1:0] SEL_SUSPEND = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CHARGE = 5'h02,
        ST_HOLD = 5'h04,
        ST_BAD = 5'h08,
        ST_DONE = 5'h10
    } chg_state_e;

endpackage

//--- hdl/fault_pattern_gen.sv
// Counter chain that produces the serrated fault pulse patterns.
`timescale 1ns/100ps
module fault_pattern_gen
    import charge_status_pkg::*;
#(
    parameter int PERIOD_CYC = PULSE_PERIOD_CYC,
    parameter int TEMP_WIDTH_CYC = TEMP_PULSE_CYC,
    parameter int BAD_WIDTH_CYC = BAD_PULSE_CYC,
    parameter int TEMP_BLINK_CYC = TEMP_HALF_CYC,
    parameter int BAD_BLINK_CYC = BAD_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic restart_in,
    output logic temp_low_out,
    output logic bad_low_out
);

    // ********************************************************************
    // Shared divider and per-pattern blink counters
    // ********************************************************************
    // One divider feeds both patterns so they stay phase-consistent.
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic [BLINK_W-1:0] tblink_ff, nxt_tblink;
    logic [BLINK_W-1:0] bblink_ff, nxt_bblink;
    logic tphase_ff, nxt_tphase;
    logic bphase_ff, nxt_bphase;
    logic temp_ff, nxt_temp;
    logic bad_ff, nxt_bad;
    logic tpulse, bpulse;

    always_comb begin // R18
        nxt_div = div_ff + DIV_W'(1);
        if (restart_in || div_ff == DIV_W'(PERIOD_CYC - 1)) begin
            nxt_div = '0;
        end
        nxt_tblink = tblink_ff + BLINK_W'(1);
        nxt_tphase = tphase_ff;
        if (restart_in) begin
            nxt_tblink = '0;
            nxt_tphase = 1'b0;
        end else if (tblink_ff == BLINK_W'(TEMP_BLINK_CYC - 1)) begin
            nxt_tblink = '0;
            nxt_tphase = ~tphase_ff;
        end
        nxt_bblink = bblink_ff + BLINK_W'(1);
        nxt_bphase = bphase_ff;
        if (restart_in) begin
            nxt_bblink = '0;
            nxt_bphase = 1'b0;
        end else if (bblink_ff == BLINK_W'(BAD_BLINK_CYC - 1)) begin
            nxt_bblink = '0;
            nxt_bphase = ~bphase_ff;
        end
        tpulse = (nxt_div < DIV_W'(TEMP_WIDTH_CYC)); // R08
        bpulse = (nxt_div < DIV_W'(BAD_WIDTH_CYC)); // R10
        // Phase 0 pulses low briefly, phase 1 pulses high briefly.
        nxt_temp = tpulse ^ nxt_tphase; // R09 R11
        nxt_bad = bpulse ^ nxt_bphase; // R10
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff <= '0;
            tblink_ff <= '0;
            bblink_ff <= '0;
            tphase_ff <= 1'b0;
            bphase_ff <= 1'b0;
            temp_ff <= 1'b0;
            bad_ff <= 1'b0;
        end else if (en_in) begin
            div_ff <= nxt_div;
            tblink_ff <= nxt_tblink;
            bblink_ff <= nxt_bblink;
            tphase_ff <= nxt_tphase;
            bphase_ff <= nxt_bphase;
            temp_ff <= nxt_temp;
            bad_ff <= nxt_bad;
        end
    end

    assign temp_low_out = temp_ff;
    assign bad_low_out = bad_ff;

endmodule

//--- verification/status_observer.sv
// Observer model of the LED and controller input on the status pin.
`timescale 1ns/100ps
module status_observer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic [15:0] low_width_out,
    output logic [15:0] high_width_out
);
    // ****************************************************************
    // Pulse width measurement
    // ****************************************************************
    // Widths are latched only at a level change, so a reading describes one
    // whole pulse; a pulse longer than 65535 cycles reads as 65535.
    logic [15:0] run_ff;
    logic last_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_ff <= 16'h0001;
            last_ff <= 1'b1;
            low_width_out <= 16'h0000;
            high_width_out <= 16'h0000;
        end else if (pin_in != last_ff) begin
            if (last_ff) begin
                high_width_out <= run_ff;
            end else begin
                low_width_out <= run_ff;
            end
            run_ff <= 16'h0001;
            last_ff <= pin_in;
        end else if (run_ff != 16'hffff) begin
            run_ff <= run_ff + 16'h0001;
        end
    end
endmodule

//--- verification/tb_top.sv
// Self-checking testbench for the charge status and fault indicator.
`timescale 1ns/100ps
module tb_top;
    import charge_status_pkg::*;
    localparam int BLINK = 20000;
    localparam int LIMIT = 60000;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cold = 1'b0, hot = 1'b0, gnd = 1'b0, ov = 1'b0;
    logic sel_lo = 1'b0, sel_hi = 1'b0, shut = 1'b0, present = 1'b0;
    logic bat_above = 1'b0, bat_low = 1'b0, rech = 1'b0;
    logic cv = 1'b0, tenth = 1'b0;
    logic en = 1'b1;
    logic pin, pin_out, oe_n, gate, path_en, chg_en;
    logic trickle, expired;
    logic [15:0] low_w, high_w;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    // The pin has a pull-up: it is high whenever nothing pulls it low.
    assign pin = oe_n ? 1'b1 : pin_out;

    charge_status_fault_indicator #(.SAFETY_CYCLES(64'd400),
        .BAD_CYCLES(64'd100), .TEMP_BLINK_CYCLES(BLINK),
        .BAD_BLINK_CYCLES(BLINK)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .en_in(en),
        .thermistor_cold_in(cold), .thermistor_hot_in(hot),
        .thermistor_sense_grounded_in(gnd),
        .overvoltage_sense_in(ov), .input_limit_sel_lo_in(sel_lo),
        .input_limit_sel_hi_in(sel_hi), .shutdown_in(shut),
        .input_present_in(present), .battery_above_load_in(bat_above),
        .battery_low_in(bat_low), .below_recharge_in(rech),
        .cv_mode_in(cv), .current_below_tenth_in(tenth),
        .charge_status_pin_in(pin), .charge_status_pin_out(pin_out),
        .charge_status_pin_oe_n_out(oe_n),
        .overvoltage_gate_drive_out(gate), .path_enable_out(path_en),
        .charge_enable_out(chg_en), .trickle_out(trickle),
        .timer_expired_out(expired));

    status_observer i_obs (.clk_in(clk_in), .rst_in(rst_in), .pin_in(pin),
        .low_width_out(low_w), .high_width_out(high_w));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            test_done();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    // Shutdown returns the charger to idle, then charging restarts.
    task automatic restart_charge();
        shut = 1'b1;
        cyc(6);
        shut = 1'b0;
        rech = 1'b1;
        present = 1'b1;
        cyc(8);
    endtask

    task automatic test_done();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_charge();
        int lows;
        lows = 0;
        rech = 1'b1;
        present = 1'b1;
        cyc(8);
        chk("charge_enable", chg_en, 1);
        for (int i = 0; i < 1000; i++) begin
            cyc(1);
            if (oe_n !== 1'b0) lows++;
        end
        chk("steady_pull_down", lows, 0);
    endtask

    // With the clock enable low nothing may move, not even the gate drive.
    task automatic t_ov();
        en = 1'b0;
        ov = 1'b1;
        cyc(4);
        chk("gate_frozen", gate, 0);
        en = 1'b1;
        cyc(4);
        chk("gate_high", gate, 1);
        chk("path_off", path_en, 0);
        ov = 1'b0;
        cyc(4);
        chk("gate_low", gate, 0);
        chk("path_on", path_en, 1);
    endtask

    task automatic t_temp();
        hot = 1'b1;
        cyc(6);
        chk("temp_stop", chg_en, 0);
        cyc(3 * PULSE_PERIOD_CYC);
        chk("temp_low_w", low_w, TEMP_PULSE_CYC);
        chk("temp_high_w", high_w, PULSE_PERIOD_CYC - TEMP_PULSE_CYC);
        cyc(16000);
        chk("inv_high_w", high_w, TEMP_PULSE_CYC);
        chk("inv_low_w", low_w, PULSE_PERIOD_CYC - TEMP_PULSE_CYC);
        hot = 1'b0;
        cyc(6);
        chk("temp_resume", chg_en, 1);
        cyc(2);
        chk("resume_pin", oe_n, 0);
        cold = 1'b1;
        cyc(6);
        chk("cold_stop", chg_en, 0);
        rech = 1'b0;
        cold = 1'b0;
        cyc(6);
        chk("no_recharge", chg_en, 0);
    endtask

    task automatic t_ground();
        restart_charge();
        gnd = 1'b1;
        hot = 1'b1;
        cyc(10);
        chk("grounded_chg", chg_en, 1);
        chk("grounded_pin", oe_n, 0);
        hot = 1'b0;
        gnd = 1'b0;
        cyc(4);
    endtask

    task automatic t_release();
        for (int k = 0; k < 3; k++) begin
            restart_charge();
            if (k == 0) {sel_hi, sel_lo} = SEL_SUSPEND;
            if (k == 1) shut = 1'b1;
            if (k == 2) {present, bat_above} = 2'h1;
            cyc(6);
            chk("released", oe_n, 1);
            if (k == 0) chk("suspend_path", path_en, 0);
            {sel_hi, sel_lo, shut, bat_above} = 4'h0;
            present = 1'b1;
            cyc(4);
        end
    endtask

    task automatic t_cv();
        restart_charge();
        cv = 1'b1;
        tenth = 1'b1;
        cyc(8);
        chk("near_done", oe_n, 1);
        cv = 1'b0;
        tenth = 1'b0;
        restart_charge();
        chk("eoc_cleared", oe_n, 0);
    endtask

    // The safety timer must keep its count through a temperature hold, so
    // it expires only after the remaining constant voltage time.
    task automatic t_timer();
        restart_charge();
        cv = 1'b1;
        cyc(300);
        hot = 1'b1;
        cyc(200);
        hot = 1'b0;
        cyc(100);
        chk("timer_kept", expired, 0);
        rech = 1'b0;
        cyc(10);
        chk("timer_expired", expired, 1);
        cv = 1'b0;
    endtask

    task automatic t_bad();
        restart_charge();
        bat_low = 1'b1;
        cyc(10);
        chk("trickle", trickle, 1);
        cyc(110);
        chk("bad_stop", chg_en, 0);
        bat_low = 1'b0;
        hot = 1'b1;
        cyc(3 * PULSE_PERIOD_CYC);
        chk("bad_low_w", low_w, BAD_PULSE_CYC);
        chk("bad_high_w", high_w, PULSE_PERIOD_CYC - BAD_PULSE_CYC);
        chk("bad_latched", chg_en, 0);
        hot = 1'b0;
        restart_charge();
        chk("bad_cleared", chg_en, 1);
    endtask

    initial begin
        cyc(10);
        chk("rst_pin", oe_n, 1);
        chk("rst_gate", gate, 0);
        cyc(10);
        rst_in = 1'b0;
        cyc(4);
        t_charge();
        t_ov();
        t_temp();
        t_ground();
        t_release();
        t_cv();
        t_timer();
        t_bad();
        test_done();
    end
endmodule
